// *** hdl/iuvfh_top.sv ***
`timescale 1ns/10ps
module iuvfh_top #(
  parameter int CONT_UNIT_CYC  = iuvfh_pkg::CONT_UNIT_CYC,
  parameter int RETRY_UNIT_CYC = iuvfh_pkg::RETRY_UNIT_CYC
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // register access, same clock
  input  wire iuvfh_pkg::iuvfh_req_t req_in,
  output logic [15:0]                rdata_out,
  output logic                       ack_out,
  // converter side, same clock
  input  wire logic [15:0]           vin_meas_in,
  input  wire logic                  output_enable_in,
  input  wire logic                  clear_faults_in,
  output logic                       regulate_out,
  output iuvfh_pkg::iuvfh_status_t   status_out,
  // open-drain alert
  output logic                       host_alert_out_n,
  output logic                       host_alert_oe_n_out
);

  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_HOLD  = 5'h02,
    ST_SPACE = 5'h04,
    ST_LATCH = 5'h08,
    ST_CLEAR = 5'h10
  } iuvfh_state_t;

  localparam logic [iuvfh_pkg::TICK_W-1:0] CONT_LAST  = iuvfh_pkg::TICK_W'(CONT_UNIT_CYC - 1);
  localparam logic [iuvfh_pkg::TICK_W-1:0] RETRY_LAST = iuvfh_pkg::TICK_W'(RETRY_UNIT_CYC - 1);

  // register file
  logic [15:0]                high_warn;
  logic [15:0]                low_warn;
  logic [15:0]                low_fault;
  iuvfh_pkg::iuvfh_reaction_t reaction;
  logic [15:0]                next_high_warn;
  logic [15:0]                next_low_warn;
  logic [15:0]                next_low_fault;
  iuvfh_pkg::iuvfh_reaction_t next_reaction;
  logic [15:0]                next_rdata;
  logic                       next_ack;

  // fault machine
  iuvfh_state_t               state;
  iuvfh_state_t               next_state;
  logic [iuvfh_pkg::TICK_W-1:0] tick;
  logic [iuvfh_pkg::TICK_W-1:0] next_tick;
  logic [2:0]                 units;
  logic [2:0]                 next_units;
  logic [2:0]                 tries;
  logic [2:0]                 next_tries;
  logic                       next_regulate;
  iuvfh_pkg::iuvfh_status_t   next_status;

  logic                       fault_now;
  logic                       warn_now;
  logic                       timer_done;

  assign fault_now = vin_meas_in < low_fault;
  assign warn_now  = (vin_meas_in > high_warn) || (vin_meas_in < low_warn);

  // where to go once the fault is known to persist with the output off
  function automatic iuvfh_state_t after_off(input logic [2:0] retries);
    after_off = (retries == iuvfh_pkg::RETRY_NONE) ? ST_LATCH : ST_SPACE;
  endfunction

  always_comb begin
    next_high_warn = high_warn;
    next_low_warn  = low_warn;
    next_low_fault = low_fault;
    next_reaction  = reaction;
    next_rdata     = rdata_out;
    next_ack       = req_in.wr || req_in.rd;
    if (req_in.wr) begin
      unique case (req_in.addr)
        iuvfh_pkg::HIGH_WARN_ADDR: next_high_warn = req_in.data;
        iuvfh_pkg::LOW_WARN_ADDR:  next_low_warn  = req_in.data;
        iuvfh_pkg::LOW_FAULT_ADDR: next_low_fault = req_in.data;
        iuvfh_pkg::REACTION_ADDR:  next_reaction  = req_in.data[7:0];
        default: ;
      endcase
    end
    if (req_in.rd) begin
      unique case (req_in.addr)
        iuvfh_pkg::HIGH_WARN_ADDR: next_rdata = high_warn;
        iuvfh_pkg::LOW_WARN_ADDR:  next_rdata = low_warn;
        iuvfh_pkg::LOW_FAULT_ADDR: next_rdata = low_fault;
        iuvfh_pkg::REACTION_ADDR:  next_rdata = {8'h00, reaction};
        default:                   next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      high_warn <= iuvfh_pkg::HIGH_WARN_RESET;
      low_warn  <= iuvfh_pkg::LOW_WARN_RESET;
      low_fault <= iuvfh_pkg::LOW_FAULT_RESET;
      reaction  <= iuvfh_pkg::REACTION_RESET;
      rdata_out <= 16'h0000;
      ack_out   <= 1'b0;
    end else begin
      high_warn <= next_high_warn;
      low_warn  <= next_low_warn;
      low_fault <= next_low_fault;
      reaction  <= next_reaction;
      rdata_out <= next_rdata;
      ack_out   <= next_ack;
    end
  end

  // the unit length follows the state: hold uses the long unit, spacing the short one
  assign timer_done = (units == reaction.delay);

  always_comb begin
    next_state  = state;
    next_tick   = tick;
    next_units  = units;
    next_tries  = tries;
    if (!timer_done) begin
      if (tick == ((state == ST_HOLD) ? CONT_LAST : RETRY_LAST)) begin
        next_tick  = '0;
        next_units = units + 3'h1;
      end else begin
        next_tick = tick + iuvfh_pkg::TICK_W'(1);
      end
    end
    unique case (state)
      ST_RUN: begin
        next_tick  = '0;
        next_units = 3'h0;
        next_tries = 3'h0;
        if (fault_now) begin
          unique case (reaction.mode)
            iuvfh_pkg::IUVFH_IGNORE:   next_state = ST_RUN;
            iuvfh_pkg::IUVFH_CONTINUE: next_state = ST_HOLD;
            iuvfh_pkg::IUVFH_DISABLE:  next_state = after_off(reaction.retries);
            iuvfh_pkg::IUVFH_UNTIL_OK: next_state = ST_CLEAR;
          endcase
        end
      end
      ST_HOLD: begin
        if (!fault_now) begin
          next_state = ST_RUN;
        end else if (timer_done) begin
          next_state = after_off(reaction.retries);
          next_tick  = '0;
          next_units = 3'h0;
        end
      end
      ST_SPACE: begin
        if (timer_done) begin
          next_tick  = '0;
          next_units = 3'h0;
          if (!fault_now) begin
            next_state = ST_RUN;
          end else if (reaction.retries == iuvfh_pkg::RETRY_FOREVER) begin
            next_state = ST_SPACE;
          end else if (tries + 3'h1 >= reaction.retries) begin
            next_state = ST_LATCH;
          end else begin
            next_tries = tries + 3'h1;
          end
        end
      end
      ST_LATCH: begin
        if (clear_faults_in && !fault_now) begin
          next_state = ST_RUN;
        end
      end
      ST_CLEAR: begin
        if (!fault_now) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
    // dropping the enable ends any retry sequence
    if (!output_enable_in) begin
      next_state = ST_RUN;
    end
    next_regulate = output_enable_in && (next_state == ST_RUN || next_state == ST_HOLD);
    // a new event wins over a clear in the same cycle
    next_status.low_fault  = fault_now || (status_out.low_fault && !clear_faults_in);
    next_status.input_warn = warn_now || (status_out.input_warn && !clear_faults_in);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state        <= ST_RUN;
      tick         <= '0;
      units        <= 3'h0;
      tries        <= 3'h0;
      regulate_out <= 1'b0;
      status_out   <= '0;
    end else begin
      state        <= next_state;
      tick         <= next_tick;
      units        <= next_units;
      tries        <= next_tries;
      regulate_out <= next_regulate;
      status_out   <= next_status;
    end
  end

  // open drain: only ever pulled low, released otherwise
  assign host_alert_out_n    = !(status_out.low_fault || status_out.input_warn);
  assign host_alert_oe_n_out = host_alert_out_n;

endmodule

// *** shared/iuvfh_pkg.sv ***
package iuvfh_pkg;

  // command codes of the supervision registers
  localparam logic [7:0]  HIGH_WARN_ADDR     = 8'h57;
  localparam logic [7:0]  LOW_WARN_ADDR      = 8'h58;
  localparam logic [7:0]  LOW_FAULT_ADDR     = 8'h59;
  localparam logic [7:0]  REACTION_ADDR      = 8'h5a;

  // values after reset: all limits inert, reaction ignores the fault
  localparam logic [15:0] HIGH_WARN_RESET    = 16'hffff;
  localparam logic [15:0] LOW_WARN_RESET     = 16'h0000;
  localparam logic [15:0] LOW_FAULT_RESET    = 16'h0000;
  localparam logic [7:0]  REACTION_RESET     = 8'h00;

  // reaction byte field positions
  localparam int          MODE_LSB           = 6;
  localparam int          RETRY_LSB          = 3;
  localparam int          DELAY_LSB          = 0;

  // timing
  localparam int          CLK_MHZ            = 100;
  localparam int          CONT_UNIT_US       = 10000;
  localparam int          RETRY_UNIT_US      = 8200;
  localparam int          CONT_UNIT_CYC      = CONT_UNIT_US * CLK_MHZ;
  localparam int          RETRY_UNIT_CYC     = RETRY_UNIT_US * CLK_MHZ;
  localparam int          TICK_W             = 24;

  localparam logic [2:0]  RETRY_NONE         = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER      = 3'h7;

  typedef enum logic [1:0] {
    IUVFH_IGNORE   = 2'h0,
    IUVFH_CONTINUE = 2'h1,
    IUVFH_DISABLE  = 2'h2,
    IUVFH_UNTIL_OK = 2'h3
  } iuvfh_mode_t;

  typedef struct packed {
    iuvfh_mode_t mode;
    logic [2:0]  retries;
    logic [2:0]  delay;
  } iuvfh_reaction_t;

  // register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] data;
  } iuvfh_req_t;

  // status flags
  typedef struct packed {
    logic        low_fault;
    logic        input_warn;
  } iuvfh_status_t;

endpackage

// *** tb/iuvfh_assertions.sv ***
`timescale 1ns/10ps
module iuvfh_checker (
  // clock and reset
  input wire logic                     clk_in,
  input wire logic                     rst_n_in,
  // watched ports
  input wire iuvfh_pkg::iuvfh_req_t    req_in,
  input wire logic                     ack_out,
  input wire logic                     output_enable_in,
  input wire logic                     clear_faults_in,
  input wire logic                     regulate_out,
  input wire iuvfh_pkg::iuvfh_status_t status_out,
  input wire logic                     host_alert_out_n,
  input wire logic                     host_alert_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ack_after_req: assert property (
    (req_in.wr || req_in.rd) |=> ack_out) else $error("request not acknowledged");
  a_no_stray_ack: assert property (
    !(req_in.wr || req_in.rd) |=> !ack_out) else $error("ack without request");
  a_fault_flag_sticky: assert property (
    status_out.low_fault && !clear_faults_in |=> status_out.low_fault)
    else $error("fault flag lost without clear");
  a_alert_from_flags: assert property (
    host_alert_out_n == !(status_out.low_fault || status_out.input_warn))
    else $error("alert does not follow flags");
  a_alert_oe_match: assert property (
    host_alert_oe_n_out == host_alert_out_n) else $error("alert enable mismatch");
  a_warn_flag_sticky: assert property (
    status_out.input_warn && !clear_faults_in |=> status_out.input_warn)
    else $error("warning flag lost without clear");
  a_enable_forces_off: assert property (
    !output_enable_in |=> !regulate_out) else $error("output on while not enabled");
  a_on_needs_enable: assert property (
    $rose(regulate_out) |-> $past(output_enable_in)) else $error("output on without enable");
endmodule

bind iuvfh_top iuvfh_checker i_chk (.clk_in, .rst_n_in, .req_in, .ack_out, .output_enable_in,
  .clear_faults_in, .regulate_out, .status_out, .host_alert_out_n, .host_alert_oe_n_out);

// *** tb/iuvfh_host.sv ***
`timescale 1ns/10ps
module iuvfh_host (
  // clock
  input  wire logic             clk_in,
  // register access
  output iuvfh_pkg::iuvfh_req_t req_out,
  input  wire logic             ack_in,
  input  wire logic [15:0]      rdata_in
);
  int misses = 0;
  initial req_out = '0;
  // bounded ack wait; a missing ack is counted, not hung on
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    @(posedge clk_in);
    req_out <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge clk_in);
    req_out <= '0;
    for (n = 0; n < 4 && ack_in !== 1'b1; n++) @(posedge clk_in);
    if (ack_in !== 1'b1) misses++;
    q = rdata_in;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    xfer(1'b0, a, 16'h0, q);
  endtask
endmodule

// *** tb/input_undervoltage_fault_handler_bench.sv ***
`timescale 1ns/10ps
module input_undervoltage_fault_handler_bench;
  logic                     clk_in = 1'b0;
  logic                     rst_n_in = 1'b0;
  iuvfh_pkg::iuvfh_req_t    req;
  logic [15:0]              rdata, got, vin = 16'h8000;
  logic                     ack, regulate, alert_n, alert_oe_n, enable = 1'b1, clear = 1'b0;
  iuvfh_pkg::iuvfh_status_t status;
  wire                      alert_line = alert_oe_n ? 1'b1 : 1'b0; // pulled up when released
  int                       fails = 0, checks_done = 0;
  logic [2:0]               tries[5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
  logic                     ons[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  always #5 clk_in = ~clk_in;
  iuvfh_top #(.CONT_UNIT_CYC(20), .RETRY_UNIT_CYC(16)) i_dut (.clk_in, .rst_n_in, .req_in(req),
    .rdata_out(rdata), .ack_out(ack), .vin_meas_in(vin), .output_enable_in(enable),
    .clear_faults_in(clear), .regulate_out(regulate), .status_out(status),
    .host_alert_out_n(alert_n), .host_alert_oe_n_out(alert_oe_n));
  iuvfh_host i_host (.clk_in, .req_out(req), .ack_in(ack), .rdata_in(rdata));
  task automatic chk_word(input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, e);
    chk_word({15'h0, g}, {15'h0, e});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    i_host.rd(a, got);
    chk_word(got, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // fault must be gone before clear, else the flag wins
  task automatic recover;
    vin <= 16'h8000;
    cyc(2);
    clear <= 1'b1;
    cyc(1);
    clear <= 1'b0;
    cyc(4);
  endtask
  task automatic print_verdict;
    fails += i_host.misses;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(16);
    rst_n_in <= 1'b1;
    rchk(8'h57, 16'hffff);
    rchk(8'h58, 16'h0000);
    rchk(8'h59, 16'h0000);
    rchk(8'h5a, 16'h0000);
    i_host.wr(8'h5b, 16'h1234);
    rchk(8'h5b, 16'h0000);
    i_host.wr(8'h57, 16'h9000);
    i_host.wr(8'h58, 16'h7000);
    i_host.wr(8'h59, 16'h6000);
    i_host.wr(8'h5a, 16'hff3f);
    rchk(8'h57, 16'h9000);
    rchk(8'h58, 16'h7000);
    rchk(8'h59, 16'h6000);
    rchk(8'h5a, 16'h003f);
    vin <= 16'h9100;
    cyc(3);
    chk_word({14'h0, status}, 16'h0001);
    chk_bit(regulate, 1'b1);
    recover;
    vin <= 16'h6800;
    cyc(3);
    chk_word({14'h0, status}, 16'h0001);
    vin <= 16'h5000;
    cyc(3);
    chk_word({14'h0, status}, 16'h0003);
    chk_bit(alert_line, 1'b0);
    chk_bit(regulate, 1'b1);
    recover;
    chk_bit(alert_line, 1'b1);
    i_host.wr(8'h5a, 16'h00c0);
    vin <= 16'h5000;
    cyc(3);
    chk_bit(regulate, 1'b0);
    vin <= 16'h8000;
    cyc(3);
    chk_bit(regulate, 1'b1);
    recover;
    i_host.wr(8'h5a, 16'h0042);
    vin <= 16'h5000;
    cyc(30);
    chk_bit(regulate, 1'b1);
    cyc(20);
    chk_bit(regulate, 1'b0);
    recover;
    foreach (tries[k]) begin
      i_host.wr(8'h5a, {8'h00, 2'h2, tries[k], 3'h1});
      vin <= 16'h5000;
      cyc(2);
      chk_bit(regulate, 1'b0);
      cyc(23);
      vin <= 16'h8000;
      cyc(35);
      chk_bit(regulate, ons[k]);
      recover;
    end
    enable <= 1'b0;
    cyc(3);
    chk_bit(regulate, 1'b0);
    enable <= 1'b1;
    cyc(3);
    chk_bit(regulate, 1'b1);
    // dropping the enable mid-spacing must end the endless retry at once
    i_host.wr(8'h5a, 16'h00b9);
    vin <= 16'h5000;
    cyc(20);
    enable <= 1'b0;
    cyc(2);
    vin <= 16'h8000;
    cyc(2);
    enable <= 1'b1;
    cyc(3);
    chk_bit(regulate, 1'b1);
    recover;
    print_verdict;
  end
endmodule
